// [asios_defines.vh]
// Constants for the sequencer interrupt and overflow status block.
// Assumes a 32-bit AXI4-Lite slave port with 8-bit byte addresses.
`ifndef ASIOS_DEFINES_VH
`define ASIOS_DEFINES_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define ASIOS_NSEQ 4
`define ASIOS_AW 8
`define ASIOS_DW 32
`define ASIOS_SW 4
`define ASIOS_FLD_MSB 3
`define ASIOS_FLD_LSB 0
`define ASIOS_RSV_W 28

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ASIOS_OFF_RAW 8'h04
`define ASIOS_OFF_MASK 8'h08
`define ASIOS_OFF_ISC 8'h0C
`define ASIOS_OFF_DROP 8'h10
`define ASIOS_OFF_DROP_EN 8'h30
`define ASIOS_OFF_CAUSE 8'h34

// ----------------------------------------------------------------
// Reset values and fills
// ----------------------------------------------------------------
`define ASIOS_RST_FLD 4'h0
`define ASIOS_RSV_FILL 28'h000_0000
`define ASIOS_ZERO_WORD 32'h0000_0000
`define ASIOS_ZERO_ADDR 8'h00
`define ASIOS_ZERO_STRB 4'h0
`define ASIOS_STRB_LANE0 0

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define ASIOS_RESP_OKAY 2'h0
`define ASIOS_RESP_DECERR 2'h3

`endif

// [asios_flag_bank.v]
// Bank of sticky flags: hardware sets, software writes one to clear.
// Assumes set and clear are single-cycle vectors from the mclk domain.
`timescale 1ns/1ps
module asios_flag_bank
#(
    parameter N = 4
)
(
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // Events and clears
    input wire [N-1:0] set_evt,
    input wire [N-1:0] clr_req,
    // State
    output reg [N-1:0] flag_r
);

    reg [N-1:0] flag_nxt;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always @*
    begin
        flag_nxt = (flag_r & ~clr_req) | set_evt;
    end

    always @(posedge mclk)
    begin
        if (!nrst)
        begin
            flag_r <= {N{1'b0}};
        end
        else
        begin
            flag_r <= flag_nxt;
        end
    end

endmodule // asios_flag_bank

// [asios_fifo_guard.v]
// Write gate in front of the sequencer result FIFOs.
// Assumes full and write request come from logic on mclk.
`timescale 1ns/1ps
module asios_fifo_guard
#(
    parameter N = 4
)
(
    // FIFO side
    input wire [N-1:0] fifo_full,
    input wire [N-1:0] fifo_write_req,
    // Results
    output wire [N-1:0] fifo_write_accept,
    output wire [N-1:0] drop_evt
);

    // ----------------------------------------------------------------
    // Gate
    // ----------------------------------------------------------------
    // newest write dropped
    assign fifo_write_accept = fifo_write_req & ~fifo_full;
    assign drop_evt = fifo_write_req & fifo_full;

endmodule // asios_fifo_guard

// [asios_top.v]
// Interrupt gating and FIFO overflow status for four sample sequencers.
// Assumes an AXI4-Lite master on mclk and sequencer logic on mclk.
//
// Operation
// - A sequencer's raw completion flag reaches the interrupt only while its promote-enable bit is one.
// - Reading a masked status bit returns raw flag AND promote-enable.
// - Each masked status bit drives a level interrupt held while raw flag and enable are both one.
// - Writing one to a masked status bit clears it and the raw flag, unless a flagged completion lands in the same cycle; zero changes nothing.
// - A one written there clears the raw flag even when the masked bit reads zero.
// - A write to a full result FIFO is discarded and sets that sequencer's sticky overflow flag.
// - An overflow flag stays set until software writes one to its bit.
// - Bits 31 to 4 of the mask, masked status and overflow registers are reserved and never altered.
// - Promote-enable bits, masked status bits and overflow flags all reset to zero.
// - A raw flag sets when a sample with its interrupt request finishes; only the clear register clears it.
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "asios_defines.vh"
module asios_top
(
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // AXI4-Lite write address
    input wire [`ASIOS_AW-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [`ASIOS_DW-1:0] s_axi_wdata,
    input wire [`ASIOS_SW-1:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [`ASIOS_AW-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [`ASIOS_DW-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Sequencer completion events
    input wire [`ASIOS_NSEQ-1:0] seq_sample_done,
    input wire [`ASIOS_NSEQ-1:0] sample_irq_request,
    // Sequencer result FIFOs
    input wire [`ASIOS_NSEQ-1:0] seq_fifo_full,
    input wire [`ASIOS_NSEQ-1:0] seq_fifo_write_req,
    output wire [`ASIOS_NSEQ-1:0] seq_fifo_write_accept,
    // Interrupts
    output wire [`ASIOS_NSEQ-1:0] seq_irq_level,
    output wire irq_out
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Word-aligned address match; low two bits ignored
    function addr_hit;
        input [`ASIOS_AW-1:0] addr;
        input [`ASIOS_AW-1:0] off;
        begin
            addr_hit = (addr[`ASIOS_AW-1:2] == off[`ASIOS_AW-1:2]);
        end
    endfunction

    // Place a 4-bit field into a word, reserved bits zero
    function [`ASIOS_DW-1:0] field_word;
        input [`ASIOS_NSEQ-1:0] fld;
        begin
            field_word = {`ASIOS_RSV_FILL, fld};
        end
    endfunction

    // Any decoded register at this address
    function addr_mapped;
        input [`ASIOS_AW-1:0] addr;
        begin
            addr_mapped = addr_hit(addr, `ASIOS_OFF_RAW) ||
                addr_hit(addr, `ASIOS_OFF_MASK) ||
                addr_hit(addr, `ASIOS_OFF_ISC) ||
                addr_hit(addr, `ASIOS_OFF_DROP) ||
                addr_hit(addr, `ASIOS_OFF_DROP_EN) ||
                addr_hit(addr, `ASIOS_OFF_CAUSE);
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg aw_held_r;
    reg [`ASIOS_AW-1:0] aw_addr_r;
    reg w_held_r;
    reg [`ASIOS_DW-1:0] w_data_r;
    reg [`ASIOS_SW-1:0] w_strb_r;
    reg [`ASIOS_NSEQ-1:0] promote_enable_r;
    reg [`ASIOS_NSEQ-1:0] promote_enable_nxt;
    reg [`ASIOS_NSEQ-1:0] drop_irq_enable_r;
    reg [`ASIOS_NSEQ-1:0] drop_irq_enable_nxt;
    reg [`ASIOS_DW-1:0] rd_word;
    reg [1:0] rd_resp;
    wire wr_go;
    wire lane0;
    wire [`ASIOS_NSEQ-1:0] wr_fld;
    wire [`ASIOS_NSEQ-1:0] raw_set;
    wire [`ASIOS_NSEQ-1:0] raw_clr;
    wire [`ASIOS_NSEQ-1:0] drop_set;
    wire [`ASIOS_NSEQ-1:0] drop_clr;
    wire [`ASIOS_NSEQ-1:0] raw_completion_r;
    wire [`ASIOS_NSEQ-1:0] fifo_drop_r;
    wire [`ASIOS_NSEQ-1:0] gated_flag;
    wire [`ASIOS_NSEQ-1:0] drop_gated;
    wire done_irq_any;
    wire drop_irq_any;

    // ----------------------------------------------------------------
    // AXI write channels
    // ----------------------------------------------------------------
    // No new address or data while a response waits; one write at a time
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
    assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
    // Only byte lane 0 holds defined bits; other lanes are reserved
    assign lane0 = w_strb_r[`ASIOS_STRB_LANE0];
    assign wr_fld = w_data_r[`ASIOS_FLD_MSB:`ASIOS_FLD_LSB];

    always @(posedge mclk)
    begin
        if (!nrst)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= `ASIOS_ZERO_ADDR;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        else if (wr_go)
        begin
            aw_held_r <= 1'b0;
        end
    end

    always @(posedge mclk)
    begin
        if (!nrst)
        begin
            w_held_r <= 1'b0;
            w_data_r <= `ASIOS_ZERO_WORD;
            w_strb_r <= `ASIOS_ZERO_STRB;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        else if (wr_go)
        begin
            w_held_r <= 1'b0;
        end
    end

    always @(posedge mclk)
    begin
        if (!nrst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ASIOS_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            if (addr_mapped(aw_addr_r))
            begin
                s_axi_bresp <= `ASIOS_RESP_OKAY;
            end
            else
            begin
                s_axi_bresp <= `ASIOS_RESP_DECERR;
            end
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @*
    begin
        promote_enable_nxt = promote_enable_r;
        drop_irq_enable_nxt = drop_irq_enable_r;
        if (wr_go && lane0 && addr_hit(aw_addr_r, `ASIOS_OFF_MASK))
        begin
            promote_enable_nxt = wr_fld;
        end
        if (wr_go && lane0 && addr_hit(aw_addr_r, `ASIOS_OFF_DROP_EN))
        begin
            drop_irq_enable_nxt = wr_fld;
        end
    end

    always @(posedge mclk)
    begin
        if (!nrst)
        begin
            promote_enable_r <= `ASIOS_RST_FLD;
            drop_irq_enable_r <= `ASIOS_RST_FLD;
        end
        else
        begin
            promote_enable_r <= promote_enable_nxt;
            drop_irq_enable_r <= drop_irq_enable_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Raw completion flags
    // ----------------------------------------------------------------
    // set by flagged sample done
    assign raw_set = seq_sample_done & sample_irq_request;
    assign raw_clr = (wr_go && lane0 && addr_hit(aw_addr_r, `ASIOS_OFF_ISC))
        ? wr_fld : `ASIOS_RST_FLD;

    asios_flag_bank
    #(
        .N(`ASIOS_NSEQ)
    )
    u_raw_bank
    (
        .mclk(mclk),
        .nrst(nrst),
        .set_evt(raw_set),
        .clr_req(raw_clr),
        .flag_r(raw_completion_r)
    );

    // ----------------------------------------------------------------
    // FIFO overflow flags
    // ----------------------------------------------------------------
    asios_fifo_guard
    #(
        .N(`ASIOS_NSEQ)
    )
    u_guard
    (
        .fifo_full(seq_fifo_full),
        .fifo_write_req(seq_fifo_write_req),
        .fifo_write_accept(seq_fifo_write_accept),
        .drop_evt(drop_set)
    );

    assign drop_clr = (wr_go && lane0 && addr_hit(aw_addr_r, `ASIOS_OFF_DROP))
        ? wr_fld : `ASIOS_RST_FLD;

    asios_flag_bank
    #(
        .N(`ASIOS_NSEQ)
    )
    u_drop_bank
    (
        .mclk(mclk),
        .nrst(nrst),
        .set_evt(drop_set),
        .clr_req(drop_clr),
        .flag_r(fifo_drop_r)
    );

    // ----------------------------------------------------------------
    // Interrupt outputs
    // ----------------------------------------------------------------
    // gate raw by enable
    assign gated_flag = raw_completion_r & promote_enable_r;
    assign seq_irq_level = gated_flag;
    assign drop_gated = fifo_drop_r & drop_irq_enable_r;
    assign done_irq_any = |gated_flag;
    assign drop_irq_any = |drop_gated;
    // Combinational OR of the gated flop outputs; not registered before the controller
    assign irq_out = done_irq_any | drop_irq_any;

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always @*
    begin
        rd_word = `ASIOS_ZERO_WORD;
        rd_resp = `ASIOS_RESP_OKAY;
        if (addr_hit(s_axi_araddr, `ASIOS_OFF_RAW))
        begin
            rd_word = field_word(raw_completion_r);
        end
        else if (addr_hit(s_axi_araddr, `ASIOS_OFF_MASK))
        begin
            rd_word = field_word(promote_enable_r);
        end
        else if (addr_hit(s_axi_araddr, `ASIOS_OFF_ISC))
        begin
            rd_word = field_word(gated_flag);
        end
        else if (addr_hit(s_axi_araddr, `ASIOS_OFF_DROP))
        begin
            rd_word = field_word(fifo_drop_r);
        end
        else if (addr_hit(s_axi_araddr, `ASIOS_OFF_DROP_EN))
        begin
            rd_word = field_word(drop_irq_enable_r);
        end
        else if (addr_hit(s_axi_araddr, `ASIOS_OFF_CAUSE))
        begin
            rd_word = field_word({2'b00, drop_irq_any, done_irq_any});
        end
        else
        begin
            rd_resp = `ASIOS_RESP_DECERR;
        end
    end

    // ----------------------------------------------------------------
    // AXI read channels
    // ----------------------------------------------------------------
    // One read at a time; reads have no side effects
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge mclk)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `ASIOS_ZERO_WORD;
            s_axi_rresp <= `ASIOS_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_resp;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // asios_top

// [asios_props.sv]
// Checker for the sequencer interrupt block, bound to asios_top.
// Assumes one clock mclk and a synchronous active-low nrst.
`timescale 1ns/1ps
module asios_props
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Sequencer side
    input wire logic [3:0] seq_sample_done,
    input wire logic [3:0] sample_irq_request,
    input wire logic [3:0] seq_fifo_full,
    input wire logic [3:0] seq_fifo_write_req,
    input wire logic [3:0] seq_fifo_write_accept,
    input wire logic [3:0] seq_irq_level,
    input wire logic irq_out
);
default clocking cb @(posedge mclk); endclocking
default disable iff (!nrst);

// --------------------------------------------------------------
// Assertions and covers
// --------------------------------------------------------------
raise_cause_a: assert property (|(seq_irq_level & ~$past(seq_irq_level)
    & ~$past(seq_sample_done & sample_irq_request)) |-> $rose(s_axi_bvalid))
    else $error("interrupt level rose without a cause");
level_fall_a: assert property (|($past(seq_irq_level) & ~seq_irq_level)
    |-> $rose(s_axi_bvalid) || !$past(nrst))
    else $error("interrupt level fell without a clear");
irq_any_a: assert property (|seq_irq_level |-> irq_out)
    else $error("interrupt output low with a level set");
accept_gate_a: assert property (seq_fifo_write_accept ==
    (seq_fifo_write_req & ~seq_fifo_full))
    else $error("fifo write accept wrong");
reset_clear_a: assert property (disable iff (1'b0) !nrst |=>
    seq_irq_level == 4'h0 && !irq_out && !s_axi_bvalid && !s_axi_rvalid)
    else $error("state not cleared by reset");
rsv_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h000_0000)
    else $error("reserved read bits not zero");
bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
irq_rise_c: cover property ($rose(irq_out));
drop_evt_c: cover property (|(seq_fifo_write_req & seq_fifo_full));
write_c: cover property ($rose(s_axi_bvalid));
endmodule // asios_props

bind asios_top asios_props u_props (.mclk, .nrst, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .seq_sample_done,
    .sample_irq_request, .seq_fifo_full, .seq_fifo_write_req,
    .seq_fifo_write_accept, .seq_irq_level, .irq_out);

// [asios_seq_model.sv]
// Model of the four sequencers and their result FIFOs.
// Assumes calls from the bench; every change lands just after a rising edge.
`timescale 1ns/1ps
module asios_seq_model
(
    // Clock
    input wire logic mclk,
    // Toward the block
    output logic [3:0] seq_sample_done,
    output logic [3:0] sample_irq_request,
    output logic [3:0] seq_fifo_full,
    output logic [3:0] seq_fifo_write_req,
    // From the block
    input wire logic [3:0] seq_fifo_write_accept
);
logic [3:0] acc_seen;
initial
begin
    seq_sample_done = 4'h0;
    sample_irq_request = 4'h0;
    seq_fifo_full = 4'h0;
    seq_fifo_write_req = 4'h0;
    acc_seen = 4'h0;
end
// samples finish, some with a request
task automatic fin(input logic [3:0] d, input logic [3:0] r, input int n);
    @(posedge mclk);
    seq_sample_done <= d;
    sample_irq_request <= r;
    repeat (n) @(posedge mclk);
    seq_sample_done <= 4'h0;
    sample_irq_request <= 4'h0;
endtask
// one write attempt per sequencer, some full
task automatic push(input logic [3:0] q, input logic [3:0] f);
    @(posedge mclk);
    seq_fifo_write_req <= q;
    seq_fifo_full <= f;
    @(posedge mclk);
    // Accept as the FIFO saw it at this edge
    acc_seen = seq_fifo_write_accept;
    seq_fifo_write_req <= 4'h0;
    seq_fifo_full <= 4'h0;
endtask
endmodule // asios_seq_model

// [asios_tb_top.sv]
// Bench for asios_top: register traffic over AXI4-Lite plus events.
// Assumes the sequencer model drives all completion and FIFO inputs.
`timescale 1ns/1ps
module asios_tb_top;
logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
logic [7:0] awaddr, araddr;
logic [31:0] wdata;
wire awready, wready, bvalid, arready, rvalid, irq;
wire [1:0] bresp, rresp;
wire [31:0] rdata;
wire [3:0] done, ireq, full, wreq, acc, lvl;
int err_total, checked;
localparam logic [1:0] OK = 2'h0;
localparam logic [1:0] DEC = 2'h3;

asios_top DUT (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .seq_sample_done(done), .sample_irq_request(ireq),
    .seq_fifo_full(full), .seq_fifo_write_req(wreq),
    .seq_fifo_write_accept(acc), .seq_irq_level(lvl), .irq_out(irq));
asios_seq_model u_seq (.mclk(mclk), .seq_sample_done(done),
    .sample_irq_request(ireq), .seq_fifo_full(full),
    .seq_fifo_write_req(wreq), .seq_fifo_write_accept(acc));

task automatic conclude;
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
        err_total++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
endtask
// Design output value copied at the call, compared after the next falling edge
task automatic sig(input logic [31:0] got, input logic [31:0] exp);
    @(negedge mclk);
    chk(got, exp);
endtask
// Handshakes judged at the rising edge, before the flops move
task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // The write response ends the wait; the watchdog ends one that never gets it
    forever
    begin
        @(posedge mclk);
        if (awvalid && awready)
            awvalid <= 1'b0;
        if (wvalid && wready)
            wvalid <= 1'b0;
        if (bvalid && bready)
        begin
            chk(32'(bresp), 32'(er));
            bready <= 1'b0;
            break;
        end
    end
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
        @(posedge mclk);
        if (arvalid && arready)
            arvalid <= 1'b0;
        if (rvalid && rready)
        begin
            chk(rdata, ed);
            chk(32'(rresp), 32'(er));
            rready <= 1'b0;
            break;
        end
    end
endtask

initial
begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
end
initial
begin
    #20000;
    err_total++;
    conclude;
end
initial
begin
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    err_total = 0;
    checked = 0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    rd(8'h08, 32'h0000_0000, OK);
    rd(8'h0C, 32'h0000_0000, OK);
    rd(8'h10, 32'h0000_0000, OK);
    rd(8'h20, 32'h0000_0000, DEC);
    wr(8'h20, 32'h0000_000F, DEC);
    u_seq.fin(4'hF, 4'h5, 1);
    rd(8'h04, 32'h0000_0005, OK);
    rd(8'h0C, 32'h0000_0000, OK);
    sig(32'(irq), 32'h0000_0000);
    wr(8'h08, 32'h0000_0006, OK);
    rd(8'h08, 32'h0000_0006, OK);
    rd(8'h0C, 32'h0000_0004, OK);
    sig(32'(lvl), 32'h0000_0004);
    sig(32'(irq), 32'h0000_0001);
    rd(8'h34, 32'h0000_0001, OK);
    wr(8'h0C, 32'h0000_0001, OK);
    rd(8'h04, 32'h0000_0004, OK);
    wr(8'h08, 32'h0000_000F, OK);
    sig(32'(lvl), 32'h0000_0004);
    wr(8'h0C, 32'h0000_0000, OK);
    sig(32'(lvl), 32'h0000_0004);
    wr(8'h0C, 32'h0000_0004, OK);
    sig(32'(irq), 32'h0000_0000);
    // Last completion lands on the very edge of the clear
    fork
        u_seq.fin(4'h1, 4'h1, 2);
        wr(8'h0C, 32'h0000_0001, OK);
    join
    sig(32'(lvl), 32'h0000_0001);
    wr(8'h0C, 32'h0000_0001, OK);
    sig(32'(lvl), 32'h0000_0000);
    u_seq.push(4'hF, 4'h5);
    chk(32'(u_seq.acc_seen), 32'h0000_000A);
    rd(8'h10, 32'h0000_0005, OK);
    repeat (20) @(posedge mclk);
    rd(8'h10, 32'h0000_0005, OK);
    wr(8'h10, 32'h0000_0001, OK);
    rd(8'h10, 32'h0000_0004, OK);
    wr(8'h30, 32'h0000_000F, OK);
    sig(32'(irq), 32'h0000_0001);
    rd(8'h34, 32'h0000_0002, OK);
    wr(8'h10, 32'h0000_0004, OK);
    sig(32'(irq), 32'h0000_0000);
    conclude;
end
endmodule // asios_tb_top
